/* src/tx_status_params.svh */
// constants and register layout for the transmit control and status block
//
// Summary of operation
// - hardware reset clears the whole transmit control register to zero.
// - software reset clears only transmit_go and pause_send_request in the control register.
// - pause_send_request self-clears when the control frame has been sent.
// - writing zero to pause_send_request does nothing.
// - bit 21 marks a pause frame sent, bit 20 any control frame.
// - bit 19 tagged, 18 broadcast, 17 multicast; 18 and 17 zero mean unicast.
// - bit 16 set when heartbeat was missing at end of transmission.
// - bit 15 shows transmission halted by transmit_go clear or immediate stop.
// - bit 14 set when a packet was sent or discarded.
// - bit 13 set on transmit fifo parity fault.
// - bit 12 set on collision after 512 bit times.
// - bit 10 set on carrier never seen or lost; bit 11 reserved.
// - bit 9 set when deferral exceeds the limit for the link speed; the block picks that limit by control bit 7 (SQE check).
// - bit 8 set when the fifo runs empty mid-frame.
// - bit 7 set when an enabled interrupt condition occurs.
// - bit 6 set when transmitter paused after the current packet.
// - bit 5 set when a packet had to defer.
// - sixteen collisions set bit 4, drop the packet, go to the next.
// - bits 3:0 count collisions; zero whenever bit 4 is set.
// - status clears on software reset and at start of each packet.
// - flags always set; interrupt raised only when enabled.
// - clearing transmit_go stops transmission at once.
`ifndef TX_STATUS_PARAMS_SVH
`define TX_STATUS_PARAMS_SVH

`define CTRL_OFFSET      8'h48
`define STAT_OFFSET      8'h4c
`define CTRL_RESET       32'h0000_0000
`define STAT_RESET       32'h0000_0000
`define CTRL_GO          0
`define CTRL_HALT_REQ    1
`define CTRL_NO_PAD      2
`define CTRL_NO_CRC      3
`define CTRL_FAST_BACK   4
`define CTRL_NO_EXDEF    5
`define CTRL_PAUSE_REQ   6
`define CTRL_SQE_CHECK   7
`define CTRL_EN_UNDER    8
`define CTRL_EN_OVERLONG_DEFERRAL_FLAG  9
`define CTRL_EN_CARRIER_LOSS_FLAG    10
`define CTRL_EN_TOO_MANY_COLLISIONS   11
`define CTRL_EN_LATE     12
`define CTRL_EN_PAR      13
`define CTRL_EN_DONE     14
`define CTRL_WIDTH       15
`define ST_PAUSE         21
`define ST_CTRL_FRAME    20
`define ST_TAGGED        19
`define ST_BCAST         18
`define ST_MCAST         17
`define ST_HEARTBEAT     16
`define ST_HALTED        15
`define ST_DONE          14
`define ST_PARITY        13
`define ST_LATE          12
`define ST_CARRIER_LOSS_FLAG         10
`define ST_OVERLONG_DEFERRAL_FLAG       9
`define ST_UNDER         8
`define ST_IRQ           7
`define ST_PAUSED        6
`define ST_DEFER         5
`define ST_TOO_MANY_COLLISIONS        4
`define ST_WIDTH         22
`define CLK_PERIOD_NS    8
`define DEFER_100_NS     242880
`define DEFER_10_NS      2428800
`define DEFER_100_CYC    (`DEFER_100_NS / `CLK_PERIOD_NS)
`define DEFER_10_CYC     (`DEFER_10_NS / `CLK_PERIOD_NS)
`define MAX_COLLISIONS   16
`define LATE_BYTES       64

`endif

/* src/tx_status_pkg.sv */
// types shared by the transmit control and status block
package tx_status_pkg;
   typedef enum logic [1:0] {
      tx_idle,
      tx_defer,
      tx_send
   } tx_state_t;
endpackage

/* src/defer_timer.sv */
// deferral timer: flags when waiting for the medium runs past the limit
`timescale 1ns/1ps
`include "tx_status_params.svh"
module defer_timer #(
   parameter int unsigned LIMIT_FAST = `DEFER_100_CYC,
   parameter int unsigned LIMIT_SLOW = `DEFER_10_CYC
) (
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic waiting,
   input  wire logic slow_link,
   output logic      overlong
);
   logic [31:0] count_reg;
   logic [31:0] count_next;
   wire  [31:0] limit_sel = slow_link ? 32'(LIMIT_SLOW) : 32'(LIMIT_FAST);
   wire         at_limit  = (count_reg >= limit_sel);

   assign count_next = !waiting ? 32'h0 : (at_limit ? count_reg : count_reg + 32'h1);
   assign overlong   = waiting && at_limit;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         count_reg <= 32'h0;
      end else begin
         count_reg <= count_next;
      end
   end
endmodule

/* src/tx_status_ctrl.sv */
// transmit control register, per-packet status word and transmit sequencer
`timescale 1ns/1ps
`include "tx_status_params.svh"
module tx_status_ctrl #(
   parameter int unsigned LIMIT_FAST = `DEFER_100_CYC,
   parameter int unsigned LIMIT_SLOW = `DEFER_10_CYC
) (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        soft_rst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   input  wire logic        immediate_stop,
   input  wire logic        pkt_ready,
   input  wire logic        pkt_is_ctrl,
   input  wire logic        pkt_is_pause,
   input  wire logic        pkt_tagged,
   input  wire logic        pkt_bcast,
   input  wire logic        pkt_mcast,
   input  wire logic        fifo_empty,
   input  wire logic        fifo_parity,
   input  wire logic        last_byte,
   input  wire logic        medium_busy,
   input  wire logic        collision_pin,
   input  wire logic        carrier_pin,
   input  wire logic        heartbeat_pin,
   input  wire logic        byte_tick,
   output logic             tx_active,
   output logic             pkt_done,
   output logic             tx_irq
);
   logic [`CTRL_WIDTH-1:0] ctrl_reg;
   logic [`CTRL_WIDTH-1:0] ctrl_next;
   logic [`ST_WIDTH-1:0]   stat_reg;
   logic [`ST_WIDTH-1:0]   stat_next;
   logic [31:0]            rdata_reg;
   logic [6:0]             byte_cnt_reg;
   logic                   active_reg;
   logic                   done_reg;
   logic                   irq_reg;
   logic                   halted_reg;
   logic                   paused_reg;
   logic                   car_seen_reg;
   tx_status_pkg::tx_state_t state_reg;
   tx_status_pkg::tx_state_t state_next;

   // three-stage pin synchronisers
   logic [2:0] col_s;
   logic [2:0] car_s;
   logic [2:0] hb_s;
   logic       col_q;
   logic       car_q;
   logic       hb_q;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         col_s <= 3'h0;
         car_s <= 3'h0;
         hb_s  <= 3'h0;
         col_q <= 1'b0;
         car_q <= 1'b0;
         hb_q  <= 1'b0;
      end else begin
         col_s <= {col_s[1:0], collision_pin};
         car_s <= {car_s[1:0], carrier_pin};
         hb_s  <= {hb_s[1:0], heartbeat_pin};
         if (col_s[1] == col_s[2]) col_q <= col_s[2];
         if (car_s[1] == car_s[2]) car_q <= car_s[2];
         if (hb_s[1] == hb_s[2]) hb_q <= hb_s[2];
      end
   end
   logic col_prev;
   always_ff @(posedge clk) begin
      if (sys_rst) col_prev <= 1'b0;
      else col_prev <= col_q;
   end
   wire col_event = col_q && !col_prev;

   // register decode
   wire sel_ctrl  = (reg_addr == `CTRL_OFFSET);
   wire sel_stat  = (reg_addr == `STAT_OFFSET);
   wire wr_ctrl   = reg_wr && sel_ctrl;
   wire go        = ctrl_reg[`CTRL_GO];
   wire stopping  = !go || immediate_stop;
   // halt is an event: the moment stopping rises, soft reset excluded
   wire halt_event = stopping && !halted_reg;
   wire [`CTRL_WIDTH-1:0] en_mask = ctrl_reg;

   // sequencer conditions
   wire in_send     = (state_reg == tx_status_pkg::tx_send);
   wire in_defer    = (state_reg == tx_status_pkg::tx_defer);
   wire start_pkt   = (state_reg == tx_status_pkg::tx_idle) && pkt_ready && !stopping
                      && !ctrl_reg[`CTRL_HALT_REQ];
   wire late        = (byte_cnt_reg >= 7'(`LATE_BYTES));
   wire coll_now    = in_send && col_event;
   wire [3:0] coll_cnt = stat_reg[3:0];
   wire coll_limit  = coll_now && !late && (coll_cnt == 4'(`MAX_COLLISIONS - 1));
   wire frame_end   = in_send && byte_tick && last_byte;
   wire underrun    = in_send && fifo_empty && !last_byte;
   // carrier lost after being seen, or never seen by the end of the frame
   wire lost_car    = in_send && !car_q && (car_seen_reg || frame_end);
   wire hb_miss     = frame_end && ctrl_reg[`CTRL_SQE_CHECK] && !hb_q;
   wire overlong;
   wire ex_defer    = overlong && !ctrl_reg[`CTRL_NO_EXDEF];
   wire finish      = frame_end || coll_limit || (coll_now && late) || underrun;
   wire abort       = (in_send || in_defer) && stopping;
   wire pkt_end     = (finish && !abort) || ex_defer;

   defer_timer #(
      .LIMIT_FAST (LIMIT_FAST),
      .LIMIT_SLOW (LIMIT_SLOW)
   ) u_defer (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .waiting   (in_defer),
      .slow_link (ctrl_reg[`CTRL_SQE_CHECK]),
      .overlong  (overlong)
   );

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         tx_status_pkg::tx_idle: begin
            if (start_pkt) state_next = tx_status_pkg::tx_defer;
         end
         tx_status_pkg::tx_defer: begin
            if (abort || ex_defer) state_next = tx_status_pkg::tx_idle;
            else if (!medium_busy) state_next = tx_status_pkg::tx_send;
         end
         tx_status_pkg::tx_send: begin
            if (abort || finish) state_next = tx_status_pkg::tx_idle;
            else if (coll_now) state_next = tx_status_pkg::tx_defer;
         end
      endcase
   end

   // control register: writes, self-clear of the pause request, soft reset
   wire pause_sent = pkt_end && pkt_is_ctrl;
   always_comb begin
      ctrl_next = ctrl_reg;
      if (wr_ctrl) begin
         ctrl_next = reg_wdata[`CTRL_WIDTH-1:0];
         ctrl_next[`CTRL_PAUSE_REQ] = ctrl_reg[`CTRL_PAUSE_REQ]
                                      | reg_wdata[`CTRL_PAUSE_REQ];
      end
      if (pause_sent) ctrl_next[`CTRL_PAUSE_REQ] = 1'b0;
      if (wr_ctrl && reg_wdata[`CTRL_PAUSE_REQ]) ctrl_next[`CTRL_PAUSE_REQ] = 1'b1;
      if (soft_rst) begin
         ctrl_next[`CTRL_GO] = 1'b0;
         ctrl_next[`CTRL_PAUSE_REQ] = 1'b0;
      end
   end

   // status word; collision count reads zero once sixteen collisions abandon the packet
   wire [3:0] coll_inc = coll_now && !coll_limit ? coll_cnt + 4'h1 : coll_cnt;
   wire any_enabled = (underrun && en_mask[`CTRL_EN_UNDER])
                    || (ex_defer && en_mask[`CTRL_EN_OVERLONG_DEFERRAL_FLAG])
                    || (lost_car && en_mask[`CTRL_EN_CARRIER_LOSS_FLAG])
                    || (coll_limit && en_mask[`CTRL_EN_TOO_MANY_COLLISIONS])
                    || (coll_now && late && en_mask[`CTRL_EN_LATE])
                    || (fifo_parity && in_send && en_mask[`CTRL_EN_PAR])
                    || (pkt_end && en_mask[`CTRL_EN_DONE])
                    || (hb_miss && en_mask[`CTRL_EN_DONE]);
   always_comb begin
      stat_next = stat_reg;
      if (start_pkt) stat_next = '0;
      if (in_send && pkt_is_pause)   stat_next[`ST_PAUSE]      = 1'b1;
      if (in_send && pkt_is_ctrl)    stat_next[`ST_CTRL_FRAME] = 1'b1;
      if (in_send && pkt_tagged)     stat_next[`ST_TAGGED]     = 1'b1;
      if (in_send && pkt_bcast)      stat_next[`ST_BCAST]      = 1'b1;
      if (in_send && pkt_mcast && !pkt_bcast) stat_next[`ST_MCAST] = 1'b1;
      if (hb_miss)                   stat_next[`ST_HEARTBEAT]  = 1'b1;
      if (halt_event)                stat_next[`ST_HALTED]     = 1'b1;
      if (pkt_end || abort)          stat_next[`ST_DONE]       = 1'b1;
      if (fifo_parity && in_send)    stat_next[`ST_PARITY]     = 1'b1;
      if (coll_now && late)          stat_next[`ST_LATE]       = 1'b1;
      if (lost_car)                  stat_next[`ST_CARRIER_LOSS_FLAG]      = 1'b1;
      if (ex_defer)                  stat_next[`ST_OVERLONG_DEFERRAL_FLAG]    = 1'b1;
      if (underrun)                  stat_next[`ST_UNDER]      = 1'b1;
      if (any_enabled)               stat_next[`ST_IRQ]        = 1'b1;
      stat_next[`ST_PAUSED] = paused_reg;
      if (in_defer && medium_busy)   stat_next[`ST_DEFER]      = 1'b1;
      if (coll_now)                  stat_next[3:0]            = coll_inc;
      if (coll_limit) begin
         stat_next[`ST_TOO_MANY_COLLISIONS] = 1'b1;
         stat_next[3:0] = 4'h0;
      end
      stat_next[11] = 1'b0;
      if (soft_rst) stat_next = '0;
   end

   // read mux; status is never written by software
   wire [31:0] rd_mux = sel_ctrl ? 32'(ctrl_reg) :
                        sel_stat ? 32'(stat_reg) : 32'h0;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_reg     <= `CTRL_WIDTH'(`CTRL_RESET);
         stat_reg     <= `ST_WIDTH'(`STAT_RESET);
         state_reg    <= tx_status_pkg::tx_idle;
         rdata_reg    <= 32'h0;
         byte_cnt_reg <= 7'h0;
         active_reg   <= 1'b0;
         done_reg     <= 1'b0;
         irq_reg      <= 1'b0;
         halted_reg   <= 1'b1;
         paused_reg   <= 1'b0;
         car_seen_reg <= 1'b0;
      end else begin
         ctrl_reg   <= ctrl_next;
         stat_reg   <= stat_next;
         state_reg  <= soft_rst ? tx_status_pkg::tx_idle : state_next;
         rdata_reg  <= reg_rd ? rd_mux : 32'h0;
         if (!in_send) byte_cnt_reg <= 7'h0;
         else if (byte_tick && !late) byte_cnt_reg <= byte_cnt_reg + 7'h1;
         active_reg <= (state_next == tx_status_pkg::tx_send) && !soft_rst;
         done_reg   <= pkt_end || abort;
         irq_reg    <= any_enabled;
         halted_reg <= stopping || soft_rst;
         car_seen_reg <= in_send && (car_seen_reg || car_q);
         paused_reg <= pkt_end ? ctrl_reg[`CTRL_HALT_REQ] :
                       (start_pkt ? 1'b0 : paused_reg);
      end
   end

   assign reg_rdata = rdata_reg;
   assign tx_active = active_reg;
   assign pkt_done  = done_reg;
   assign tx_irq    = irq_reg;

   // checks
   soft_reset_ctl_a: assert property (@(posedge clk) disable iff (sys_rst)
      soft_rst |=> !ctrl_reg[`CTRL_GO] && !ctrl_reg[`CTRL_PAUSE_REQ] && stat_reg == '0)
      else $error("soft reset left go, pause request or status set");
   pause_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      ctrl_reg[`CTRL_PAUSE_REQ] && !soft_rst && !pause_sent |=> ctrl_reg[`CTRL_PAUSE_REQ])
      else $error("pause request dropped without frame completion");
   pause_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
      pause_sent && !(wr_ctrl && reg_wdata[`CTRL_PAUSE_REQ]) |=> !ctrl_reg[`CTRL_PAUSE_REQ])
      else $error("pause request not cleared after control frame");
   too_many_collisions_count_a: assert property (@(posedge clk) disable iff (sys_rst)
      stat_reg[`ST_TOO_MANY_COLLISIONS] |-> stat_reg[3:0] == 4'h0)
      else $error("collision count nonzero with excessive flag");
   too_many_collisions_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
      coll_limit && !soft_rst |=> state_reg == tx_status_pkg::tx_idle && stat_reg[`ST_TOO_MANY_COLLISIONS])
      else $error("packet not abandoned after sixteen collisions");
   stop_now_a: assert property (@(posedge clk) disable iff (sys_rst)
      in_send && !go |=> state_reg == tx_status_pkg::tx_idle ##1 !tx_active)
      else $error("transmission continued after go cleared");
   halt_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
      $fell(go) && !$past(immediate_stop) && !$past(soft_rst) && !soft_rst
      |=> stat_reg[`ST_HALTED])
      else $error("halted flag missing");
   start_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
      start_pkt && !soft_rst |=> stat_reg[`ST_DONE] == 1'b0 && stat_reg[3:0] == 4'h0)
      else $error("status not cleared at packet start");
   irq_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
      tx_irq |-> $past(any_enabled))
      else $error("interrupt without enabled condition");
   read_delay_a: assert property (@(posedge clk) disable iff (sys_rst)
      reg_rd && sel_stat |=> reg_rdata == 32'($past(stat_reg)))
      else $error("status read data wrong");
   hw_reset_a: assert property (@(posedge clk)
      sys_rst |=> ctrl_reg == '0)
      else $error("control register not zero after reset");
   cov_done_c: cover property (@(posedge clk) disable iff (sys_rst) frame_end);
   cov_too_many_collisions_c: cover property (@(posedge clk) disable iff (sys_rst) coll_limit);
   cov_pause_c: cover property (@(posedge clk) disable iff (sys_rst) pause_sent);
   cov_stop_c: cover property (@(posedge clk) disable iff (sys_rst) abort);
endmodule

/* testbench/phy_model.sv */
// far-side transceiver: carrier echo, heartbeat after frames, collisions on demand
`timescale 1ns/1ps
module phy_model (
   input  wire logic       clk,
   input  wire logic       tx_active,
   input  wire logic [4:0] coll_req,
   input  wire logic       coll_load,
   output logic            collision_pin,
   output logic            carrier_pin,
   output logic            heartbeat_pin
);
   logic [4:0] coll_left = 5'h00;
   logic [3:0] run = 4'h0;
   logic       was_active = 1'b0;
   initial begin
      collision_pin = 1'b0;
      carrier_pin = 1'b0;
      heartbeat_pin = 1'b0;
   end
   always @(posedge clk) begin
      was_active <= tx_active;
      run <= !tx_active ? 4'h0 : (run == 4'hf) ? run : run + 4'h1;
      carrier_pin <= tx_active;
      heartbeat_pin <= was_active && !tx_active;
      // early collision, well inside the first 64 bytes
      if (coll_load) begin
         coll_left <= coll_req;
      end else if (run == 4'h3 && coll_left != 5'h00) begin
         collision_pin <= 1'b1;
         coll_left <= coll_left - 5'h01;
      end
      if (run == 4'h9 || !tx_active) begin
         collision_pin <= 1'b0;
      end
   end
endmodule

/* testbench/mac_transmit_status_bench.sv */
// self-checking bench for the transmit control and status block
`timescale 1ns/1ps
`include "tx_status_params.svh"
module mac_transmit_status_bench;
   logic        clk = 0, sys_rst = 1, soft_rst = 0, reg_wr = 0, reg_rd = 0;
   logic [7:0]  reg_addr = 8'h00, nbytes = 8'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, seed = 32'h37564f84, v;
   logic        immediate_stop = 0, pkt_ready = 0, fifo_empty = 0, byte_tick = 0;
   logic        pkt_is_ctrl = 0, pkt_is_pause = 0, pkt_tagged = 0, pkt_bcast = 0;
   logic        pkt_mcast = 0, last_byte = 0, medium_busy = 0, fifo_parity = 0;
   logic        collision_pin, carrier_pin, heartbeat_pin, tx_active, pkt_done, tx_irq;
   logic        rd_q = 0, under_mode = 0, coll_load = 0;
   logic [4:0]  coll_req = 5'h00, f;
   logic [63:0] exp_q[$];
   logic [63:0] e;
   int          n_fail = 0, n_compared = 0, n_irq = 0, i;
   always #4 clk = ~clk;
   tx_status_ctrl #(.LIMIT_FAST(50), .LIMIT_SLOW(100)) uut (.clk(clk), .sys_rst(sys_rst),
      .soft_rst(soft_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .immediate_stop(immediate_stop),
      .pkt_ready(pkt_ready), .pkt_is_ctrl(pkt_is_ctrl), .pkt_is_pause(pkt_is_pause),
      .pkt_tagged(pkt_tagged), .pkt_bcast(pkt_bcast), .pkt_mcast(pkt_mcast),
      .fifo_empty(fifo_empty), .fifo_parity(fifo_parity), .last_byte(last_byte),
      .medium_busy(medium_busy), .collision_pin(collision_pin), .carrier_pin(carrier_pin),
      .heartbeat_pin(heartbeat_pin), .byte_tick(byte_tick), .tx_active(tx_active),
      .pkt_done(pkt_done), .tx_irq(tx_irq));
   phy_model phy (.clk(clk), .tx_active(tx_active), .coll_req(coll_req),
      .coll_load(coll_load), .collision_pin(collision_pin), .carrier_pin(carrier_pin),
      .heartbeat_pin(heartbeat_pin));
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk) reg_wr <= 1'b0;
      @(posedge clk);
   endtask
   // expected word and mask are noted before the strobe goes out
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
      reg_addr <= a;
      reg_rd <= 1'b1;
      exp_q.push_back({exp, m});
      @(posedge clk) reg_rd <= 1'b0;
      @(posedge clk);
   endtask
   task automatic send(input logic [4:0] fl);
      {pkt_is_pause, pkt_is_ctrl, pkt_tagged, pkt_bcast, pkt_mcast} <= fl;
      pkt_ready <= 1'b1;
      for (int k = 0; k < 20000; k++) begin
         @(posedge clk);
         if (pkt_done === 1'b1) break;
      end
      pkt_ready <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   always @(posedge clk) begin
      rd_q <= reg_rd;
      if (tx_irq === 1'b1) n_irq++;
      if (rd_q) begin
         e = exp_q.pop_front();
         check(reg_rdata & e[31:0], e[63:32], "register read");
      end
   end
   // byte stream toward the block while it sends
   always @(posedge clk) begin
      nbytes <= tx_active ? nbytes + 8'h01 : 8'h00;
      byte_tick <= tx_active;
      last_byte <= tx_active && nbytes == 8'd28;
      fifo_empty <= under_mode && tx_active && nbytes == 8'd10;
      if (tx_active) pkt_ready <= 1'b0;
   end
   initial begin
      repeat (60000) @(posedge clk);
      n_fail++;
      end_of_test();
   end
   initial begin
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      rd(`CTRL_OFFSET, 32'h0, 32'hffff_ffff);
      rd(`STAT_OFFSET, 32'h0, 32'hffff_ffff);
      $display("reset values done");
      wr(`CTRL_OFFSET, 32'h1 | (32'h1 << `CTRL_EN_DONE));
      for (i = 0; i < 6; i++) begin
         f = 5'(xs());
         f[3] = f[3] | f[4];
         if (f[1]) f[0] = 1'b0;
         send(f);
         rd(`STAT_OFFSET, {10'h0, f, 17'h0} | 32'h4080, 32'h3e_4480);
      end
      check(n_irq, 6, "done interrupts");
      $display("frame types done");
      v = xs() & 32'h7faf;
      wr(`CTRL_OFFSET, v);
      soft_rst <= 1'b1;
      @(posedge clk) soft_rst <= 1'b0;
      @(posedge clk);
      rd(`CTRL_OFFSET, v & 32'h7fae, 32'hffff_ffff);
      rd(`STAT_OFFSET, 32'h0, 32'hffff_ffff);
      wr(`STAT_OFFSET, 32'hffff_ffff);
      rd(`STAT_OFFSET, 32'h0, 32'hffff_ffff);
      rd(8'h10, 32'h0, 32'hffff_ffff);
      $display("software reset done");
      wr(`CTRL_OFFSET, 32'h40);
      wr(`CTRL_OFFSET, 32'h0);
      rd(`CTRL_OFFSET, 32'h40, 32'h41);
      wr(`CTRL_OFFSET, 32'h41);
      send(5'h18);
      rd(`CTRL_OFFSET, 32'h1, 32'h41);
      $display("pause request done");
      wr(`CTRL_OFFSET, 32'h1 | (32'h1 << `CTRL_EN_UNDER));
      under_mode <= 1'b1;
      n_irq = 0;
      send(5'h00);
      under_mode <= 1'b0;
      rd(`STAT_OFFSET, 32'h180, 32'h180);
      check(n_irq, 1, "underrun interrupt");
      $display("underrun done");
      // fast back-off bit is written but the block never reads it; retries restart once the medium is free
      wr(`CTRL_OFFSET, 32'h1 | (32'h1 << `CTRL_FAST_BACK));
      for (i = 0; i < 2; i++) begin
         coll_req <= (i == 0) ? 5'd3 : 5'd16;
         coll_load <= 1'b1;
         @(posedge clk) coll_load <= 1'b0;
         send(5'h00);
         rd(`STAT_OFFSET, (i == 0) ? 32'h4003 : 32'h4010, 32'h401f);
      end
      $display("collisions done");
      wr(`CTRL_OFFSET, 32'h1);
      medium_busy <= 1'b1;
      pkt_ready <= 1'b1;
      @(posedge clk) pkt_ready <= 1'b0;
      repeat (60) @(posedge clk);
      medium_busy <= 1'b0;
      rd(`STAT_OFFSET, 32'h4220, 32'h4220);
      $display("deferral done");
      for (i = 0; i < 2; i++) begin
         wr(`CTRL_OFFSET, 32'h1);
         pkt_ready <= 1'b1;
         for (int k = 0; k < 200 && tx_active !== 1'b1; k++) @(posedge clk);
         if (i == 0) wr(`CTRL_OFFSET, 32'h0);
         else immediate_stop <= 1'b1;
         pkt_ready <= 1'b0;
         repeat (2) @(posedge clk);
         check(tx_active, 1'b0, "transmit after stop");
         rd(`STAT_OFFSET, 32'hc000, 32'hc000);
         immediate_stop <= 1'b0;
      end
      $display("halt done");
      repeat (4) @(posedge clk);
      end_of_test();
   end
endmodule
